/* File: pwm_seq_pkg.sv */
// Purpose: shared constants, types and register map of the bridge pwm sequencer
// Assumes: 200 MHz system clock, axi4-lite register access
// Notes:   every count of cycles but the register reset values and OSC_PERIOD_MIN is derived here from its time and the clock rate
package pwm_seq_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned EN_MIN_PULSE_NS = 3000;
  localparam int unsigned BLANK_EXTRA_NS  = 70;
  localparam int unsigned SYNC_MIN_HZ     = 170_000;
  localparam int unsigned SYNC_MAX_HZ     = 2_300_000;

  localparam int unsigned QUAL_W   = 10;
  localparam int unsigned OSC_W    = 12;
  localparam int unsigned DLY_W    = 8;
  localparam int unsigned TMR_W    = 9;

  // least times round up, longest times round down
  localparam logic [QUAL_W-1:0] EN_MIN_PULSE_CYC =
    QUAL_W'((EN_MIN_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [TMR_W-1:0] BLANK_EXTRA_CYC =
    TMR_W'((BLANK_EXTRA_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [OSC_W-1:0] OSC_MAX_PERIOD_CYC = OSC_W'(CLK_HZ / SYNC_MIN_HZ);
  localparam logic [OSC_W-1:0] OSC_MIN_PERIOD_CYC =
    OSC_W'((CLK_HZ + SYNC_MAX_HZ - 1) / SYNC_MAX_HZ);

  ////////////////////////////////////////////////////////////////////////////////
  // register map
  localparam int unsigned AXI_AW = 8;
  localparam int unsigned AXI_DW = 32;

  localparam logic [AXI_AW-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [AXI_AW-1:0] ADDR_DEAD   = 8'h04;
  localparam logic [AXI_AW-1:0] ADDR_OSC    = 8'h08;
  localparam logic [AXI_AW-1:0] ADDR_STATUS = 8'h0c;

  localparam int unsigned CTRL_SYNC_BIT  = 0;
  localparam int unsigned CTRL_CMODE_BIT = 1;
  localparam int unsigned DEAD_SP_LSB    = 0;
  localparam int unsigned DEAD_PS_LSB    = 8;

  localparam logic [1:0]       CTRL_RST       = 2'h0;
  localparam logic [DLY_W-1:0] DEAD_SP_RST    = 8'h08;
  localparam logic [DLY_W-1:0] DEAD_PS_RST    = 8'h08;
  localparam logic [OSC_W-1:0] OSC_PERIOD_RST = 12'h1f4;
  localparam logic [OSC_W-1:0] OSC_PERIOD_MIN = 12'h002;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_DISABLED,
    ST_QUALIFY,
    ST_RUN_FIRST,
    ST_LEVEL,
    ST_PULSE,
    ST_PULSE_OFF
  } en_state_t;

  typedef struct packed {
    logic supply_above_rise;
    logic supply_above_fall;
    logic ref_valid;
    logic temp_below_shutdown;
    logic overvoltage_sense;
    logic ss_above_threshold;
    logic hiccup_active;
    logic pwm_compare;
  } sense_t;

  typedef struct packed {
    logic primary_drive_a;
    logic primary_drive_b;
    logic rectifier_drive_a;
    logic rectifier_drive_b;
  } drive_t;

endpackage

/* File: sync2.sv */
// Purpose: two flip-flop synchroniser for a vector of pin levels
// Assumes: each bit is an independent level
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module sync2 #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule

/* File: dead_timer.sv */
// Purpose: loadable down-counter for dead times and blanking
// Assumes: load of zero is handled by the caller
// Notes:   expire pulses in the last counted cycle
`timescale 1ns/1ps
module dead_timer #(
  parameter int unsigned W = 9
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // control
  input  wire logic         clear,
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  // status
  output logic              busy,
  output logic              expire
);

  logic [W-1:0] cnt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
    end else if (clear) begin
      cnt_q <= '0;
    end else if (start) begin
      cnt_q <= load;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign busy   = (cnt_q != '0);
  assign expire = (cnt_q == W'(1));

endmodule

/* File: bridge_pwm_enable_sequencer.sv */
// Purpose: enable sequencing, oscillator and bridge drive timing
// Assumes: comparator results and pins arrive asynchronously
// Notes:   analog soft-start and regulation stay outside
`timescale 1ns/1ps
module bridge_pwm_enable_sequencer (
  // clock and reset
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  // axi4-lite write
  input  wire logic [pwm_seq_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [pwm_seq_pkg::AXI_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  // axi4-lite read
  input  wire logic [pwm_seq_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [pwm_seq_pkg::AXI_DW-1:0]      s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  // comparator and pin inputs
  input  wire pwm_seq_pkg::sense_t            sense_in,
  input  wire logic                           enable_in,
  input  wire logic                           osc_timing_sync_input,
  // power stage
  output pwm_seq_pkg::drive_t                 drive_out,
  output logic                                ramp_pulldown,
  output logic                                ss_charge_en,
  output logic                                ss_discharge
);
  import pwm_seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  localparam int unsigned SYNC_W = $bits(sense_t) + 2;

  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync_out;
  sense_t            sn;
  logic              en_s;
  logic              ext_s;

  assign raw_in = {sense_in, enable_in, osc_timing_sync_input};

  sync2 #(.W(SYNC_W)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (raw_in),
    .dout    (sync_out)
  );

  assign sn    = sense_t'(sync_out[SYNC_W-1:2]);
  assign en_s  = sync_out[1];
  assign ext_s = sync_out[0];

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  logic [1:0]       ctrl_q;
  logic [DLY_W-1:0] sp_sel_q;
  logic [DLY_W-1:0] ps_sel_q;
  logic [OSC_W-1:0] osc_period_q;

  ////////////////////////////////////////////////////////////////////////////////
  // enable state machine
  en_state_t         state_q;
  logic              armed_q;
  logic              ocp_flag_q;
  logic [QUAL_W-1:0] qual_cnt_q;
  logic              qual_done;
  logic              startup_ok;
  logic              fault;
  logic              running;
  logic              switch_en;

  assign startup_ok = sn.supply_above_rise & sn.ref_valid & sn.temp_below_shutdown &
                      ~sn.overvoltage_sense;
  assign fault      = ~sn.ref_valid | ~sn.temp_below_shutdown | sn.overvoltage_sense;
  assign qual_done  = en_s & (qual_cnt_q == EN_MIN_PULSE_CYC - QUAL_W'(1));
  assign running    = (state_q == ST_RUN_FIRST) | (state_q == ST_LEVEL) |
                      (state_q == ST_PULSE) | (state_q == ST_PULSE_OFF);
  assign switch_en  = running & ~sn.hiccup_active;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_STANDBY;
    end else if (!sn.supply_above_fall) begin
      state_q <= ST_STANDBY;
    end else begin
      case (state_q)
        ST_STANDBY: begin
          if (sn.supply_above_rise) state_q <= ST_DISABLED;
        end
        ST_DISABLED: begin
          if (armed_q && en_s && startup_ok) state_q <= ST_QUALIFY;
        end
        ST_QUALIFY: begin
          if (!en_s) state_q <= ST_DISABLED;
          else if (qual_done) state_q <= ST_RUN_FIRST;
        end
        ST_RUN_FIRST: begin
          if (fault) state_q <= ST_DISABLED;
          else if (!en_s) state_q <= ST_PULSE;
          else if (sn.ss_above_threshold) state_q <= ST_LEVEL;
        end
        ST_LEVEL: begin
          if (fault) state_q <= ST_DISABLED;
          else if (!en_s && ocp_flag_q && !sn.ss_above_threshold) state_q <= ST_PULSE;
          else if (!en_s) state_q <= ST_DISABLED;
        end
        ST_PULSE: begin
          if (fault) state_q <= ST_DISABLED;
          else if (en_s) state_q <= ST_PULSE_OFF;
        end
        ST_PULSE_OFF: begin
          if (fault) state_q <= ST_DISABLED;
          else if (!en_s) state_q <= ST_PULSE;
          else if (qual_done) state_q <= ST_DISABLED;
        end
        default: state_q <= ST_STANDBY;
      endcase
    end
  end

  // re-arm only after enable has been seen low or in stand-by, so a held level does not restart
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_q <= 1'b1;
    end else if (state_q == ST_STANDBY || !en_s) begin
      armed_q <= 1'b1;
    end else if (state_q == ST_PULSE_OFF && qual_done) begin
      armed_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      qual_cnt_q <= '0;
    end else if (!en_s || (state_q != ST_QUALIFY && state_q != ST_PULSE_OFF)) begin
      qual_cnt_q <= '0;
    end else if (!qual_done) begin
      qual_cnt_q <= qual_cnt_q + QUAL_W'(1);
    end
  end

  // overcurrent discharge marker; set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ocp_flag_q <= 1'b0;
    end else if (sn.hiccup_active) begin
      ocp_flag_q <= 1'b1;
    end else if (!running || sn.ss_above_threshold) begin
      ocp_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ss_charge_en <= 1'b0;
      ss_discharge <= 1'b1;
    end else begin
      ss_charge_en <= switch_en;
      ss_discharge <= ~switch_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // oscillator with external sync
  logic [OSC_W-1:0] osc_cnt_q;
  logic [OSC_W-1:0] osc_limit;
  logic             ext_prev_q;
  logic             ext_fall;
  logic             sync_take;
  logic             cycle_start;
  logic             sync_lock_q;
  logic             phase_q;

  assign ext_fall    = ext_prev_q & ~ext_s;
  assign osc_limit   = ctrl_q[CTRL_SYNC_BIT] ? OSC_MAX_PERIOD_CYC : osc_period_q;
  assign sync_take   = ctrl_q[CTRL_SYNC_BIT] & ext_fall &
                       (osc_cnt_q >= OSC_MIN_PERIOD_CYC - OSC_W'(1));
  assign cycle_start = switch_en & ((osc_cnt_q >= osc_limit - OSC_W'(1)) | sync_take);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_s;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_cnt_q <= '0;
    end else if (!switch_en || cycle_start) begin
      osc_cnt_q <= '0;
    end else begin
      osc_cnt_q <= osc_cnt_q + OSC_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_lock_q <= 1'b0;
    end else if (sync_take) begin
      sync_lock_q <= 1'b1;
    end else if (cycle_start || !ctrl_q[CTRL_SYNC_BIT]) begin
      sync_lock_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= 1'b1;
    end else if (!switch_en) begin
      phase_q <= 1'b1;
    end else if (cycle_start) begin
      phase_q <= ~phase_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // dead times, blanking and drive sequencing
  logic       sp_busy, sp_expire, ps_busy, ps_expire, blank_busy;
  logic       prim_on_q;
  logic       ps_phase_q;
  logic [1:0] rect_q;
  logic       prim_turn_on;
  logic       prim_turn_off;

  dead_timer #(.W(TMR_W)) u_sp_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (~switch_en),
    .start   (cycle_start & (sp_sel_q != '0)),
    .load    ({1'b0, sp_sel_q}),
    .busy    (sp_busy),
    .expire  (sp_expire)
  );

  dead_timer #(.W(TMR_W)) u_ps_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (~switch_en),
    .start   (prim_turn_off & (ps_sel_q != '0)),
    .load    ({1'b0, ps_sel_q}),
    .busy    (ps_busy),
    .expire  (ps_expire)
  );

  dead_timer #(.W(TMR_W)) u_blank_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (~switch_en),
    .start   (cycle_start),
    .load    ({1'b0, sp_sel_q} + BLANK_EXTRA_CYC),
    .busy    (blank_busy),
    .expire  ()
  );

  assign prim_turn_on  = (cycle_start & (sp_sel_q == '0)) | sp_expire;
  assign prim_turn_off = prim_on_q & (cycle_start | (sn.pwm_compare & ~blank_busy));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prim_on_q <= 1'b0;
    end else if (!switch_en) begin
      prim_on_q <= 1'b0;
    end else if (prim_turn_on) begin
      prim_on_q <= 1'b1;
    end else if (prim_turn_off) begin
      prim_on_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ps_phase_q <= 1'b0;
    end else if (prim_turn_off) begin
      ps_phase_q <= phase_q;
    end
  end

  // rectifier of the new phase drops at cycle start; the other one stays on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rect_q <= 2'h0;
    end else if (!switch_en) begin
      rect_q <= 2'h0;
    end else begin
      if (cycle_start) rect_q[~phase_q] <= 1'b0;
      if (prim_turn_off && ps_sel_q == '0) rect_q[phase_q] <= 1'b1;
      else if (ps_expire) rect_q[ps_phase_q] <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_out     <= '0;
      ramp_pulldown <= 1'b0;
    end else begin
      drive_out.primary_drive_a   <= switch_en & prim_on_q & ~phase_q;
      drive_out.primary_drive_b   <= switch_en & prim_on_q & phase_q;
      drive_out.rectifier_drive_a <= switch_en & rect_q[0];
      drive_out.rectifier_drive_b <= switch_en & rect_q[1];
      ramp_pulldown <= switch_en & blank_busy & ~ctrl_q[CTRL_CMODE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  logic              aw_have_q, w_have_q, do_write;
  logic [AXI_AW-1:0] awaddr_q;
  logic [AXI_DW-1:0] wdata_q, wmask, dead_new, osc_new;
  logic [3:0]        wstrb_q;

  assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_write      = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign wmask         = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign dead_new      = ({16'h0000, ps_sel_q, sp_sel_q} & ~wmask) | (wdata_q & wmask);
  assign osc_new       = ({20'h00000, osc_period_q} & ~wmask) | (wdata_q & wmask);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_q == ADDR_CTRL || awaddr_q == ADDR_DEAD ||
                       awaddr_q == ADDR_OSC) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q       <= CTRL_RST;
      sp_sel_q     <= DEAD_SP_RST;
      ps_sel_q     <= DEAD_PS_RST;
      osc_period_q <= OSC_PERIOD_RST;
    end else if (do_write) begin
      if (awaddr_q == ADDR_CTRL && wstrb_q[0]) ctrl_q <= wdata_q[1:0];
      if (awaddr_q == ADDR_DEAD) begin
        sp_sel_q <= dead_new[DEAD_SP_LSB +: DLY_W];
        ps_sel_q <= dead_new[DEAD_PS_LSB +: DLY_W];
      end
      if (awaddr_q == ADDR_OSC) begin
        osc_period_q <= (osc_new[OSC_W-1:0] < OSC_PERIOD_MIN) ? OSC_PERIOD_MIN
                                                                : osc_new[OSC_W-1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL:   s_axi_rdata <= {30'h00000000, ctrl_q};
        ADDR_DEAD:   s_axi_rdata <= {16'h0000, ps_sel_q, sp_sel_q};
        ADDR_OSC:    s_axi_rdata <= {20'h00000, osc_period_q};
        ADDR_STATUS: s_axi_rdata <= {20'h00000, drive_out, ocp_flag_q, sync_lock_q,
                                     phase_q, startup_ok, 1'b0, state_q};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* File: pwm_seq_properties.sv */
// Purpose: port checks of the bridge pwm sequencer
// Assumes: dead times of 4 and 8 cycles
// Notes:   bound into every sequencer
`timescale 1ns/1ps
module pwm_seq_checker (
  // clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // inputs watched
  input wire pwm_seq_pkg::sense_t sense_in,
  input wire logic                enable_in,
  // power stage
  input wire pwm_seq_pkg::drive_t drive_out,
  input wire logic                ramp_pulldown,
  input wire logic                ss_charge_en,
  input wire logic                ss_discharge
);
  import pwm_seq_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  logic       en_q;
  logic [9:0] hi_len_q;
  // length of the latest enable high stretch
  always_ff @(posedge aclk) begin
    en_q <= enable_in;
    if (!aresetn) hi_len_q <= 10'h0;
    else if (enable_in && !en_q) hi_len_q <= 10'h1;
    else if (enable_in && hi_len_q != 10'h3ff) hi_len_q <= hi_len_q + 10'h1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_supply_lost;
    !sense_in.supply_above_fall [*6];
  endsequence
  property p_standby_off;
    s_supply_lost |-> drive_out == 4'h0 && ss_discharge && !ss_charge_en;
  endproperty
  property p_start_ok;
    $rose(ss_charge_en) |-> sense_in.supply_above_rise && sense_in.ref_valid &&
      sense_in.temp_below_shutdown && !sense_in.overvoltage_sense;
  endproperty
  property p_ss_excl;
    ss_charge_en |-> !ss_discharge;
  endproperty
  property p_one_primary;
    !(drive_out.primary_drive_a && drive_out.primary_drive_b);
  endproperty
  property p_rect_first;
    $rose(drive_out.primary_drive_a) |-> !$past(drive_out.rectifier_drive_a, 3);
  endproperty
  property p_rect_after;
    $fell(drive_out.primary_drive_a) |-> !drive_out.rectifier_drive_a [*4];
  endproperty
  property p_blank;
    $rose(ramp_pulldown) |-> (ramp_pulldown || !ss_charge_en) [*8];
  endproperty
  property p_min_pulse;
    $rose(ss_charge_en) |-> hi_len_q >= EN_MIN_PULSE_CYC - 10'h2;
  endproperty
  a_standby_off: assert property (p_standby_off) else $error("stand-by outputs");
  a_start_ok: assert property (p_start_ok) else $error("start without good inputs");
  a_ss_excl: assert property (p_ss_excl) else $error("charge and discharge");
  a_one_primary: assert property (p_one_primary) else $error("both primaries on");
  a_rect_first: assert property (p_rect_first) else $error("rectifier late off");
  a_rect_after: assert property (p_rect_after) else $error("rectifier early on");
  a_blank: assert property (p_blank) else $error("blanking too short");
  a_min_pulse: assert property (p_min_pulse) else $error("short enable taken");
endmodule

bind bridge_pwm_enable_sequencer pwm_seq_checker u_pwm_seq_checker (
  .aclk(aclk), .aresetn(aresetn), .sense_in(sense_in), .enable_in(enable_in),
  .drive_out(drive_out), .ramp_pulldown(ramp_pulldown), .ss_charge_en(ss_charge_en),
  .ss_discharge(ss_discharge)
);

/* File: stage_model.sv */
// Purpose: gate drive load and external sync source
// Assumes: sync_half of 0 parks the sync line high
// Notes:   measures primary a period in clocks
`timescale 1ns/1ps
module stage_model #(
  parameter int CMP_ON = 30
) (
  // clock
  input wire logic                aclk,
  // gate drives and sync control
  input wire pwm_seq_pkg::drive_t drive,
  input wire logic [31:0]         sync_half,
  // to the controller
  output logic                    sync,
  output logic                    cmp,
  // measurements
  output int                      gap,
  output int                      rises
);
  import pwm_seq_pkg::*;
  int   t = 0;
  int   last = 0;
  int   ton = 0;
  int   hc = 0;
  logic pa_q = 1'b0;
  initial begin
    sync = 1'b1;
    cmp = 1'b0;
    gap = 0;
    rises = 0;
  end
  always @(posedge aclk) begin
    t <= t + 1;
    pa_q <= drive.primary_drive_a;
    if (drive.primary_drive_a && !pa_q) begin
      gap <= t - last;
      last <= t;
      rises <= rises + 1;
    end
    // sensed current reaches the error level after a fixed on-time
    ton <= (drive.primary_drive_a || drive.primary_drive_b) ? ton + 1 : 0;
    cmp <= ton >= CMP_ON;
    if (sync_half == 0) begin
      sync <= 1'b1;
      hc <= 0;
    end else if (hc >= sync_half - 1) begin
      sync <= !sync;
      hc <= 0;
    end else begin
      hc <= hc + 1;
    end
  end
endmodule

/* File: tb.sv */
// Purpose: self-checking bench of the bridge pwm sequencer
// Assumes: dead times 4 and 8 cycles
// Notes:   expectations from the register map and timing constants
`timescale 1ns/1ps
module tb;
  import pwm_seq_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn, enable_in, osc_timing_sync_input, cmp;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, ramp_pulldown, ss_charge_en, ss_discharge;
  sense_t      sense_in, sv;
  drive_t      drive_out;
  int          sync_half, gap, rises, p;
  int          err_total = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int unsigned seed = 9430;

  assign sense_in = {sv[7:1], cmp};
  always #2.5 aclk = ~aclk;

  bridge_pwm_enable_sequencer u_bridge_pwm_enable_sequencer (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sense_in, .enable_in,
    .osc_timing_sync_input, .drive_out, .ramp_pulldown, .ss_charge_en, .ss_discharge
  );
  stage_model u_stage_model (
    .aclk, .drive(drive_out), .sync_half, .sync(osc_timing_sync_input), .cmp, .gap, .rises
  );
  ////////////////////////////////////////////////////////////////////////////////
  function automatic int rnd(input int m);
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed % m);
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    if (err_total == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      if (s_axi_awready) pa = 1'b0;
      if (s_axi_wready) pw = 1'b0;
      @(posedge aclk);
      if (!pa) s_axi_awvalid <= 1'b0;
      if (!pw) s_axi_wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
  endtask
  task automatic st(input logic [2:0] e);
    repeat (12) @(posedge aclk);
    rd(ADDR_STATUS);
    chk("state", 32'(e), 32'(d[2:0]));
  endtask
  task automatic pulse(input int n);
    @(posedge aclk);
    enable_in <= 1'b1;
    repeat (n) @(posedge aclk);
    enable_in <= 1'b0;
    repeat (20) @(posedge aclk);
  endtask
  task automatic lvl();
    @(posedge aclk);
    enable_in <= 1'b1;
    repeat (700) @(posedge aclk);
    sv.ss_above_threshold <= 1'b1;
    st(3'h4);
  endtask
  task automatic per(input int e);
    int n;
    n = rises;
    wait (rises >= n + 3);
    @(negedge aclk);
    chk("period", 32'(e), 32'(gap));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    logic [7:0]  ra [3];
    logic [31:0] rv [3];
    ra = '{ADDR_CTRL, ADDR_DEAD, ADDR_OSC};
    rv = '{{30'h0, CTRL_RST}, {16'h0, DEAD_PS_RST, DEAD_SP_RST}, {20'h0, OSC_PERIOD_RST}};
    {aresetn, enable_in, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, sync_half} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
    sv = 8'hf0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i]);
      chk("reset value", rv[i], d);
      chk("rresp", 32'(RESP_OKAY), 32'(r));
    end
    rd(8'h10);
    chk("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
    chk("unmapped rdata", 32'h0, d);
    wr(ADDR_STATUS, 32'h7);
    chk("status bresp", 32'(RESP_SLVERR), 32'(r));
    wr(ADDR_DEAD, 32'h0804);
    rd(ADDR_DEAD);
    chk("dead", 32'h0804, d);
    rd(ADDR_STATUS);
    chk("startup ok", 32'h1, 32'(d[4]));
    pulse(50 + rnd(400));
    st(3'h1);
    chk("charge", 32'h0, 32'(ss_charge_en));
    pulse(700);
    st(3'h5);
    chk("charge", 32'h1, 32'(ss_charge_en));
    p = 100 + rnd(200);
    wr(ADDR_OSC, 32'(p));
    per(2 * p);
    pulse(700);
    st(3'h1);
    chk("discharge", 32'h1, 32'(ss_discharge));
    lvl();
    wr(ADDR_OSC, 32'hfff);
    wr(ADDR_CTRL, 32'h1);
    p = 60 + rnd(70);
    sync_half <= p;
    per(4 * p);
    sync_half = 0;
    per(2 * int'(OSC_MAX_PERIOD_CYC));
    @(posedge aclk);
    enable_in <= 1'b0;
    sv.ss_above_threshold <= 1'b0;
    st(3'h1);
    lvl();
    sv.supply_above_rise <= 1'b0;
    sv.supply_above_fall <= 1'b0;
    st(3'h0);
    chk("drive", 32'h0, 32'(drive_out));
    wrap_up();
  end
endmodule
